/* verilog/irqc_controller.sv */
// Interrupt controller with flag, enable and global gating behind classic Wishbone.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
// Behaviour
// (R1) Global enable gates every interrupt request
// (R2) Reset clears global enable
// (R3) Return from handler sets global enable
// (R4) Flags set regardless of any enable
// (R5) Software clears stale flag before enabling
// (R6) Main control register layout, all zero reset
// (R7) Peripheral group enable gates peripheral sources
// (R8) Timer0 rollover sets flag, software clears
// (R9) External pin event sets flag, software clears
// (R10) Port-B pin change sets flag, software clears
// (R11) Software sets mask and input direction
// (R12) First peripheral enable register layout
// (R13) Second peripheral enable register layout
// (R14) First peripheral flag register layout
// (R15) Receive flag follows buffer, read clears
// (R16) Transmit flag shows empty, write clears
// (R17) Second flag register: low-voltage, write-done
// (R18) Write completion sets flag, software clears
// (R19) Accepted interrupt vectors to 0004H
// (R20) No automatic context save on entry
// (R21) No new interrupt while handler runs
// (R22) No hardware priority among sources
// (R23) Edge select chooses rising or falling
// (R24) Per-pin port-B change mask, zero reset
// (R25) Request when flag, enable, global set
// (R26) Acceptance clears global enable with branch
module irqc_controller
  import irqc_pkg::*;
#(
  parameter int PORTB_W = 8
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  // Classic Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [IRQC_ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Source events, one-cycle pulses; external and port-B pins are levels
  input wire logic timer0_rollover_in,
  input wire logic ext_pin_in,
  input wire logic [PORTB_W-1:0] portb_pins_in,
  input wire logic adc_done_in,
  input wire logic pwm_period_in,
  input wire logic timer2_match_in,
  input wire logic timer1_overflow_in,
  input wire logic low_voltage_in,
  input wire logic nv_write_done_in,
  input wire logic touch_m0_done_in,
  input wire logic touch_m1_done_in,
  input wire logic porta_change_in,
  // Serial levels and buffer accesses
  input wire logic uart_rx_full_in,
  input wire logic uart_rx_buffer_read_in,
  input wire logic uart_tx_empty_in,
  input wire logic uart_tx_buffer_write_in,
  // Core handshake
  input wire logic irq_accept_in,
  input wire logic return_from_handler_in,
  output logic irq_req_out,
  output logic in_handler_out,
  output logic vector_load_out,
  output logic [15:0] vector_addr_out
);

  // Register map, byte address = 4 * index, data in the low byte:
  //   main control        index 0x00b, byte 0x02c
  //   peripheral flags A  index 0x00c, byte 0x030
  //   peripheral flags B  index 0x00d, byte 0x034
  //   peripheral enable A index 0x106, byte 0x418
  //   peripheral enable B index 0x108, byte 0x420
  //   port-B change mask  index 0x110, byte 0x440
  //   edge select         index 0x111, byte 0x444, bit 0
  //   extra flag status   index 0x112, byte 0x448
  // Unmapped addresses still acknowledge, read zero and drop writes.
  // A write needs sel[0]; the upper three lanes carry nothing.
  //
  // Flag policy:
  //   Hardware set always wins over a software clear in the same cycle,
  //   so an event landing on the clearing write is never lost.
  //   Receive and transmit flags are not stored by software at all:
  //   they follow the buffer levels with one cycle of lag, and the
  //   buffer access pulse masks them for the one cycle after it is high.
  //   Port-A change and the two touch flags live in the status word
  //   and are cleared by writing ones there.
  //   The low-voltage flag has no enable and never requests.
  //
  // Request path:
  //   Each source but low-voltage pairs a flag with its enable; peripheral sources also
  //   need the group enable, and everything needs the global enable.
  //   The result is registered, so the request trails its cause by
  //   one cycle. There is no ordering among sources: the handler must
  //   poll the flags to decide what to serve first.
  //
  // Core handshake:
  //   An acceptance pulse while the request stands clears the global
  //   enable, enters the handler state and raises the branch pulse
  //   with the fixed vector. Nothing of the core context is saved here.
  //   The return pulse sets the global enable again and leaves the
  //   handler; a still pending request shows two cycles after the return pulse.
  //   Acceptance wins over return when both arrive together.
  //   Software setting the global enable inside the handler does not
  //   re-open requests until the return, so nesting cannot happen.
  //
  // Clock enable low freezes every register, bus answer included,
  // so a master must not expect an answer while it is low.
  //
  // Pin history is loaded from the pins during reset, so a pin that
  // idles high does not look like an edge on the first cycle out.

  // Register storage
  logic [7:0] main_reg; // Main control
  logic [7:0] flags_a_reg; // Peripheral flags A (software-clear bits only)
  logic [7:0] flags_b_reg; // Peripheral flags B
  logic [7:0] en_a_reg; // Peripheral enables A
  logic [7:0] en_b_reg; // Peripheral enables B
  logic [PORTB_W-1:0] portb_mask_reg; // Per-pin change mask
  logic edge_sel_reg; // 1 rising, 0 falling
  logic ext_prev_reg; // Last external pin level
  logic [PORTB_W-1:0] portb_prev_reg; // Last port-B levels
  logic in_handler_reg; // Service routine running
  logic rx_flag_reg; // Receive buffer holds a character
  logic tx_flag_reg; // Transmit buffer empty
  logic porta_flag_reg; // Port-A change, reported in status
  logic tkm0_flag_reg; // Touch M0 done
  logic tkm1_flag_reg; // Touch M1 done

  // Bus decode
  logic bus_req;
  logic wr_en;
  logic [8:0] reg_idx;
  logic [7:0] wdat;
  logic [7:0] flags_a_view;
  logic [7:0] flags_b_view;
  logic ext_edge;
  logic portb_change;
  logic main_pending;
  logic periph_pending;
  logic take_irq;

  // Word index from byte address
  function automatic logic [8:0] word_index(input logic [IRQC_ADDR_W-1:0] adr);
    word_index = adr[IRQC_ADDR_W-1:2];
  endfunction : word_index

  // Write strobe for one register index
  function automatic logic hit(input logic [8:0] idx, input logic [8:0] want, input logic we);
    hit = we && (idx == want);
  endfunction : hit

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_en = bus_req && wb_we_in && wb_sel_in[0];
  assign reg_idx = word_index(wb_adr_in);
  assign wdat = wb_dat_in[7:0];

  // Assembled flag views
  always_comb begin
    flags_a_view = flags_a_reg & IRQC_SW_CLR_A;
    flags_a_view[IRQC_RX_BIT] = rx_flag_reg; // R15
    flags_a_view[IRQC_TX_BIT] = tx_flag_reg; // R16
    flags_b_view = flags_b_reg & IRQC_MASK_FL_B; // R17
  end

  // Edge and change detection on source pins
  assign ext_edge = edge_sel_reg ? (ext_pin_in && !ext_prev_reg) :
                    (!ext_pin_in && ext_prev_reg); // R23
  assign portb_change = |((portb_pins_in ^ portb_prev_reg) & portb_mask_reg); // R24

  // Pending requests per group, no ordering among sources
  assign main_pending = (main_reg[IRQC_TIMER0_OVERFLOW_EN_BIT] && main_reg[IRQC_T0F_BIT]) ||
                        (main_reg[IRQC_EXTIE_BIT] && main_reg[IRQC_EXTF_BIT]) ||
                        (main_reg[IRQC_PBIE_BIT] && main_reg[IRQC_PBF_BIT]); // R25 R22
  assign periph_pending = main_reg[IRQC_PERIPHERAL_GROUP_ENABLE_BIT] &&
                          (|(flags_a_view & en_a_reg & IRQC_MASK_A) ||
                           (en_b_reg[IRQC_NV_BIT] && flags_b_reg[IRQC_NV_BIT]) ||
                           (en_b_reg[IRQC_PORTA_BIT] && porta_flag_reg) ||
                           (en_b_reg[IRQC_TKM0_BIT] && tkm0_flag_reg) ||
                           (en_b_reg[IRQC_TKM1_BIT] && tkm1_flag_reg)); // R7 R25
  assign take_irq = irq_accept_in && irq_req_out; // R21

  // Main control register: set beats clear on every flag
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      main_reg <= IRQC_RESET_BYTE; // R2 R6
    end else if (clk_en_in) begin
      logic [7:0] nxt;
      nxt = main_reg;
      if (hit(reg_idx, IRQC_IDX_MAIN, wr_en)) begin
        nxt = wdat; // R6
      end
      if (take_irq) begin
        nxt[IRQC_GIE_BIT] = 1'b0; // R26
      end else if (return_from_handler_in) begin
        nxt[IRQC_GIE_BIT] = 1'b1; // R3
      end
      if (timer0_rollover_in) begin
        nxt[IRQC_T0F_BIT] = 1'b1; // R8 R4
      end
      if (ext_edge) begin
        nxt[IRQC_EXTF_BIT] = 1'b1; // R9 R4
      end
      if (portb_change) begin
        nxt[IRQC_PBF_BIT] = 1'b1; // R10 R4
      end
      main_reg <= nxt;
    end
  end

  // Peripheral flags A: software-clear bits
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      flags_a_reg <= IRQC_RESET_BYTE;
    end else if (clk_en_in) begin
      logic [7:0] nxt;
      nxt = flags_a_reg;
      if (hit(reg_idx, IRQC_IDX_FLAGS_A, wr_en)) begin
        nxt = wdat & IRQC_SW_CLR_A; // R14
      end
      if (adc_done_in) begin
        nxt[IRQC_ADC_BIT] = 1'b1; // R4
      end
      if (pwm_period_in) begin
        nxt[IRQC_PWM_BIT] = 1'b1; // R4
      end
      if (timer2_match_in) begin
        nxt[IRQC_TMR2_BIT] = 1'b1; // R4
      end
      if (timer1_overflow_in) begin
        nxt[IRQC_TMR1_BIT] = 1'b1; // R4
      end
      flags_a_reg <= nxt;
    end
  end

  // Serial flags track buffers; buffer access clears, a new level sets
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rx_flag_reg <= 1'b0;
      tx_flag_reg <= 1'b0;
    end else if (clk_en_in) begin
      rx_flag_reg <= uart_rx_full_in && !uart_rx_buffer_read_in; // R15
      tx_flag_reg <= uart_tx_empty_in && !uart_tx_buffer_write_in; // R16
    end
  end

  // Peripheral flags B and extra peripheral flags
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      flags_b_reg <= IRQC_RESET_BYTE;
      porta_flag_reg <= 1'b0;
      tkm0_flag_reg <= 1'b0;
      tkm1_flag_reg <= 1'b0;
    end else if (clk_en_in) begin
      logic [7:0] nxt;
      logic [7:0] st;
      nxt = flags_b_reg;
      st = {tkm1_flag_reg, tkm0_flag_reg, 5'h00, porta_flag_reg};
      if (hit(reg_idx, IRQC_IDX_FLAGS_B, wr_en)) begin
        nxt = wdat & IRQC_MASK_FL_B; // R17
      end
      if (hit(reg_idx, IRQC_IDX_STATUS, wr_en)) begin
        st = st & ~wdat; // Write one to clear
      end
      if (low_voltage_in) begin
        nxt[IRQC_LVD_BIT] = 1'b1; // R4
      end
      if (nv_write_done_in) begin
        nxt[IRQC_NV_BIT] = 1'b1; // R18
      end
      flags_b_reg <= nxt;
      porta_flag_reg <= st[0] || porta_change_in;
      tkm0_flag_reg <= st[6] || touch_m0_done_in;
      tkm1_flag_reg <= st[7] || touch_m1_done_in;
    end
  end

  // Enable, mask and edge select registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      en_a_reg <= IRQC_RESET_BYTE;
      en_b_reg <= IRQC_RESET_BYTE;
      portb_mask_reg <= '0;
      edge_sel_reg <= IRQC_EDGE_RESET[0];
    end else if (clk_en_in) begin
      if (hit(reg_idx, IRQC_IDX_ENABLES_A, wr_en)) begin
        en_a_reg <= wdat & IRQC_MASK_A; // R12
      end
      if (hit(reg_idx, IRQC_IDX_ENABLES_B, wr_en)) begin
        en_b_reg <= wdat & IRQC_MASK_EN_B; // R13
      end
      if (hit(reg_idx, IRQC_IDX_PORTB_MASK, wr_en)) begin
        portb_mask_reg <= wdat[PORTB_W-1:0]; // R24
      end
      if (hit(reg_idx, IRQC_IDX_EDGE_SEL, wr_en)) begin
        edge_sel_reg <= wdat[0]; // R23
      end
    end
  end

  // Pin history for edge and change detection
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ext_prev_reg <= ext_pin_in; // Follow the idle level, no false edge
      portb_prev_reg <= portb_pins_in;
    end else if (clk_en_in) begin
      ext_prev_reg <= ext_pin_in;
      portb_prev_reg <= portb_pins_in;
    end
  end

  // Core side: request, handler state and vector; no context is saved here
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_req_out <= 1'b0;
      in_handler_reg <= 1'b0;
      vector_load_out <= 1'b0;
      vector_addr_out <= IRQC_VECTOR;
    end else if (clk_en_in) begin
      irq_req_out <= main_reg[IRQC_GIE_BIT] && !in_handler_reg && !take_irq &&
                     (main_pending || periph_pending); // R1 R21 R25
      vector_load_out <= take_irq; // R19 R20
      vector_addr_out <= IRQC_VECTOR; // R19
      if (take_irq) begin
        in_handler_reg <= 1'b1; // R21
      end else if (return_from_handler_in) begin
        in_handler_reg <= 1'b0; // R3
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      in_handler_out <= 1'b0;
    end else if (clk_en_in) begin
      in_handler_out <= take_irq || (in_handler_reg && !return_from_handler_in);
    end
  end

  // Wishbone answer: one wait state, ack for one cycle, unmapped read zero
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else if (clk_en_in) begin
      wb_ack_out <= bus_req;
      wb_dat_out <= '0;
      if (bus_req && !wb_we_in) begin
        unique case (reg_idx)
          IRQC_IDX_MAIN: wb_dat_out[7:0] <= main_reg;
          IRQC_IDX_FLAGS_A: wb_dat_out[7:0] <= flags_a_view; // R14
          IRQC_IDX_FLAGS_B: wb_dat_out[7:0] <= flags_b_view;
          IRQC_IDX_ENABLES_A: wb_dat_out[7:0] <= en_a_reg;
          IRQC_IDX_ENABLES_B: wb_dat_out[7:0] <= en_b_reg;
          IRQC_IDX_PORTB_MASK: wb_dat_out[PORTB_W-1:0] <= portb_mask_reg;
          IRQC_IDX_EDGE_SEL: wb_dat_out[0] <= edge_sel_reg;
          IRQC_IDX_STATUS: wb_dat_out[7:0] <= {tkm1_flag_reg, tkm0_flag_reg, 5'h00,
                                                porta_flag_reg};
          default: wb_dat_out <= '0;
        endcase
      end
    end
  end

endmodule : irqc_controller

/* verilog/irqc_pkg.sv */
// Package for the microcontroller interrupt controller: offsets, fields, resets.
package irqc_pkg;
  // Register indices as printed (not all multiples of four, so byte address = 4 * index)
  localparam logic [8:0] IRQC_IDX_MAIN = 9'h00b;
  localparam logic [8:0] IRQC_IDX_FLAGS_A = 9'h00c;
  localparam logic [8:0] IRQC_IDX_FLAGS_B = 9'h00d;
  localparam logic [8:0] IRQC_IDX_ENABLES_A = 9'h106;
  localparam logic [8:0] IRQC_IDX_ENABLES_B = 9'h108;
  // Own registers: port-B change mask, edge select and extra flag status
  localparam logic [8:0] IRQC_IDX_PORTB_MASK = 9'h110;
  localparam logic [8:0] IRQC_IDX_EDGE_SEL = 9'h111;
  localparam logic [8:0] IRQC_IDX_STATUS = 9'h112;
  localparam int IRQC_ADDR_W = 11;
  // Main control fields
  localparam int IRQC_GIE_BIT = 7;
  localparam int IRQC_PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int IRQC_TIMER0_OVERFLOW_EN_BIT = 5;
  localparam int IRQC_EXTIE_BIT = 4;
  localparam int IRQC_PBIE_BIT = 3;
  localparam int IRQC_T0F_BIT = 2;
  localparam int IRQC_EXTF_BIT = 1;
  localparam int IRQC_PBF_BIT = 0;
  // Flags A fields
  localparam int IRQC_ADC_BIT = 6;
  localparam int IRQC_RX_BIT = 5;
  localparam int IRQC_TX_BIT = 4;
  localparam int IRQC_PWM_BIT = 2;
  localparam int IRQC_TMR2_BIT = 1;
  localparam int IRQC_TMR1_BIT = 0;
  // Flags B / enables B fields
  localparam int IRQC_LVD_BIT = 7;
  localparam int IRQC_TKM1_BIT = 7;
  localparam int IRQC_TKM0_BIT = 6;
  localparam int IRQC_NV_BIT = 4;
  localparam int IRQC_PORTA_BIT = 1;
  // Implemented-bit masks
  localparam logic [7:0] IRQC_MASK_A = 8'h77;
  localparam logic [7:0] IRQC_MASK_EN_B = 8'hd2;
  localparam logic [7:0] IRQC_MASK_FL_B = 8'h90;
  localparam logic [7:0] IRQC_SW_CLR_A = 8'h47;
  localparam logic [7:0] IRQC_RESET_BYTE = 8'h00;
  localparam logic [7:0] IRQC_EDGE_RESET = 8'h01;
  // Vector address of the service routine
  localparam logic [15:0] IRQC_VECTOR = 16'h0004;
endpackage : irqc_pkg

/* bench/irqc_core_model.sv */
// Behavioural processor core: takes requests and runs a handler of set length.
`timescale 1ns/1ps
module irqc_core_model (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic enable_in,
  input wire logic req_in,
  input wire logic [7:0] stay_in,
  output logic accept_out = 1'b0,
  output logic return_out = 1'b0
);
  logic [7:0] count_reg = 8'h00; // Cycles left in the handler
  logic busy_reg = 1'b0; // Handler running
  // Accept one request, stay in the handler, then return
  always_ff @(posedge clock_in) begin
    accept_out <= 1'b0;
    return_out <= 1'b0;
    if (srst_in) begin
      busy_reg <= 1'b0;
      count_reg <= 8'h00;
    end else if (!busy_reg && enable_in && req_in && !accept_out) begin
      accept_out <= 1'b1;
      busy_reg <= 1'b1;
      count_reg <= stay_in;
    end else if (busy_reg && count_reg == 8'h00) begin
      return_out <= 1'b1;
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      count_reg <= count_reg - 8'h01;
    end
  end
endmodule : irqc_core_model

/* bench/irqc_assertions.sv */
// Concurrent checks on the interrupt controller ports.
`timescale 1ns/1ps
module irqc_assertions
  import irqc_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic irq_accept_in,
  input wire logic return_from_handler_in,
  input wire logic irq_req_out,
  input wire logic in_handler_out,
  input wire logic vector_load_out,
  input wire logic [15:0] vector_addr_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  property p_rst; $fell(srst_in) |-> !irq_req_out && !in_handler_out; endproperty
  a_rst: assert property (p_rst) else $error("core outputs not clear after reset");
  property p_acc; irq_accept_in && irq_req_out |=> vector_load_out && in_handler_out
    && !irq_req_out; endproperty
  a_acc: assert property (p_acc) else $error("acceptance not answered");
  property p_load; vector_load_out |-> $past(irq_accept_in) && $past(irq_req_out); endproperty
  a_load: assert property (p_load) else $error("branch without acceptance");
  property p_vec; vector_load_out |-> vector_addr_out == IRQC_VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector address");
  property p_busy; in_handler_out |-> !irq_req_out; endproperty
  a_busy: assert property (p_busy) else $error("request inside handler");
  property p_ret; in_handler_out && return_from_handler_in |=> !in_handler_out; endproperty
  a_ret: assert property (p_ret) else $error("handler not left on return");
  property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  property p_dat; wb_dat_out[31:8] == 24'h0 && (wb_ack_out || wb_dat_out == 32'h0);
  endproperty
  a_dat: assert property (p_dat) else $error("read data out of place");
  c_load: cover property (vector_load_out);
  c_ret: cover property (in_handler_out && return_from_handler_in);
  c_req: cover property (irq_req_out);
endmodule : irqc_assertions
bind irqc_controller irqc_assertions u_chk (.clock_in(clock_in), .srst_in(srst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .irq_accept_in(irq_accept_in),
  .return_from_handler_in(return_from_handler_in), .irq_req_out(irq_req_out),
  .in_handler_out(in_handler_out), .vector_load_out(vector_load_out),
  .vector_addr_out(vector_addr_out));

/* bench/testbench.sv */
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
module testbench;
  import irqc_pkg::*;
  // Row: events, setup write, main write, register read back, request
  typedef struct {logic [11:0] ev; logic [10:0] ea; logic [7:0] ed; logic [7:0] md;
    logic [10:0] fa; logic [7:0] fd; logic rq;} irqc_row_s;
  irqc_row_s rows[13] = '{
    '{12'h001, 11'h7fc, 8'hff, 8'ha0, 11'h02c, 8'ha4, 1'b1},
    '{12'h001, 11'h7fc, 8'hff, 8'h20, 11'h02c, 8'h24, 1'b0},
    '{12'h002, 11'h7fc, 8'hff, 8'h90, 11'h02c, 8'h92, 1'b1},
    '{12'h004, 11'h440, 8'h01, 8'h88, 11'h02c, 8'h89, 1'b1},
    '{12'h008, 11'h418, 8'h40, 8'hc0, 11'h030, 8'h40, 1'b1},
    '{12'h008, 11'h418, 8'h40, 8'h80, 11'h030, 8'h40, 1'b0},
    '{12'h008, 11'h418, 8'h00, 8'hc0, 11'h030, 8'h40, 1'b0},
    '{12'h070, 11'h418, 8'h07, 8'hc0, 11'h030, 8'h07, 1'b1},
    '{12'h080, 11'h420, 8'hd2, 8'hc0, 11'h034, 8'h80, 1'b0},
    '{12'h100, 11'h420, 8'h10, 8'hc0, 11'h034, 8'h10, 1'b1},
    '{12'he00, 11'h420, 8'hc2, 8'hc0, 11'h448, 8'hc1, 1'b1},
    '{12'h000, 11'h418, 8'hff, 8'h00, 11'h418, 8'h77, 1'b0},
    '{12'h000, 11'h420, 8'hff, 8'h00, 11'h420, 8'hd2, 1'b0}};
  logic [10:0] zeros[8] = '{11'h02c, 11'h030, 11'h034, 11'h418, 11'h420, 11'h440,
    11'h448, 11'h7fc};
  logic clock_in = 1'b0, srst_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic rxf = 1'b0, txe = 1'b0, mdl_en = 1'b0, acc, ret, rdp = 1'b0, wrp = 1'b0;
  logic [10:0] adr = 11'h0;
  logic [31:0] dat = 32'h0, q, rd;
  logic [11:0] ev = 12'h0;
  logic req, hnd, vld, ack;
  logic [15:0] vadr;
  int bad_count = 0, samples_checked = 0;
  always #12.5 clock_in = ~clock_in;
  irqc_controller dut (.clock_in(clock_in), .srst_in(srst_in), .clk_en_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
    .wb_dat_in(dat), .wb_dat_out(rd), .wb_ack_out(ack), .timer0_rollover_in(ev[0]),
    .ext_pin_in(ev[1]), .portb_pins_in({7'h0, ev[2]}), .adc_done_in(ev[3]),
    .pwm_period_in(ev[4]), .timer2_match_in(ev[5]), .timer1_overflow_in(ev[6]),
    .low_voltage_in(ev[7]), .nv_write_done_in(ev[8]), .touch_m0_done_in(ev[9]),
    .touch_m1_done_in(ev[10]), .porta_change_in(ev[11]), .uart_rx_full_in(rxf),
    .uart_rx_buffer_read_in(rdp), .uart_tx_empty_in(txe), .uart_tx_buffer_write_in(wrp),
    .irq_accept_in(acc), .return_from_handler_in(ret), .irq_req_out(req),
    .in_handler_out(hnd), .vector_load_out(vld), .vector_addr_out(vadr));
  irqc_core_model core (.clock_in(clock_in), .srst_in(srst_in), .enable_in(mdl_en),
    .req_in(req), .stay_in(8'd20), .accept_out(acc), .return_out(ret));
  // Print counts and verdict, then stop
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin @(posedge clock_in); n++; end while (ack !== 1'b1 && n < 50);
    q = rd;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin bad_count++; finish_test(); end
  endtask : wb
  // Bounded wait: s=0 for branch pulse, s=1 for handler end
  task automatic wait_on(input int s);
    int n;
    n = 0;
    do begin @(posedge clock_in); n++; end
    while ((s == 0 ? vld : !hnd) !== 1'b1 && n < 200);
    if (n >= 200) begin bad_count++; finish_test(); end
  endtask : wait_on
  // Short synchronous reset between cases
  task automatic rst;
    @(posedge clock_in) srst_in <= 1'b1;
    @(posedge clock_in) srst_in <= 1'b0;
  endtask : rst
  initial begin
    repeat (20) @(posedge clock_in);
    srst_in <= 1'b0;
    foreach (zeros[i]) begin wb(1'b0, zeros[i], 8'h0); chk(q, 32'h0); end
    wb(1'b0, 11'h444, 8'h0);
    chk(q, 32'h1);
    $display("reset values done");
    foreach (rows[i]) begin
      rst();
      wb(1'b1, rows[i].ea, rows[i].ed);
      wb(1'b1, 11'h02c, rows[i].md);
      @(posedge clock_in) ev <= rows[i].ev;
      @(posedge clock_in) ev <= 12'h0;
      repeat (3) @(posedge clock_in);
      chk({31'h0, req}, {31'h0, rows[i].rq});
      wb(1'b0, rows[i].fa, 8'h0);
      chk(q, {24'h0, rows[i].fd});
      $display("row %0d done", i);
    end
    // Full service cycle through the core model
    rst();
    mdl_en <= 1'b1;
    wb(1'b1, 11'h02c, 8'ha0);
    @(posedge clock_in) ev <= 12'h001;
    @(posedge clock_in) ev <= 12'h0;
    wait_on(0);
    chk({16'h0, vadr}, 32'h4);
    wb(1'b0, 11'h02c, 8'h0);
    chk(q, 32'h24);
    wb(1'b1, 11'h02c, 8'h20);
    wait_on(1);
    wb(1'b0, 11'h02c, 8'h0);
    chk(q, 32'ha0);
    chk({31'h0, req}, 32'h0);
    mdl_en <= 1'b0;
    $display("handler done");
    // Serial flags follow buffer levels, writes ignored
    rst();
    rxf <= 1'b1; txe <= 1'b1;
    wb(1'b1, 11'h030, 8'h0);
    wb(1'b0, 11'h030, 8'h0);
    chk(q, 32'h30);
    rdp <= 1'b1; wrp <= 1'b1;
    wb(1'b0, 11'h030, 8'h0);
    chk(q, 32'h0);
    rdp <= 1'b0; wrp <= 1'b0;
    rxf <= 1'b0; txe <= 1'b0;
    wb(1'b0, 11'h030, 8'h0);
    chk(q, 32'h0);
    // Falling edge selected: only the falling edge counts
    rst();
    wb(1'b1, 11'h444, 8'h0);
    @(posedge clock_in) ev <= 12'h002;
    repeat (3) @(posedge clock_in);
    wb(1'b0, 11'h02c, 8'h0);
    chk(q, 32'h0);
    @(posedge clock_in) ev <= 12'h0;
    repeat (3) @(posedge clock_in);
    wb(1'b0, 11'h02c, 8'h0);
    chk(q, 32'h2);
    $display("edge cases done");
    finish_test();
  end
endmodule : testbench
